// ---- shared/sink_driver_pkg.sv ----
package sink_driver_pkg;

    localparam int CHANNELS = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 2;

    // pins as seen at the device boundary, sampled together
    typedef struct packed {
        logic shift_strobe;
        logic latch_strobe;
        logic chain_input;
        logic wipe_low;
        logic out_enable_low;
    } pin_bundle_t;

    // idle levels: wipe released, outputs disabled
    localparam pin_bundle_t PINS_RESET = 5'h03;
    localparam logic [CHANNELS-1:0] LATCH_RESET = 12'h000;
    localparam logic CHAIN_RESET = 1'b0;

endpackage

// ---- core/snapshot_fifo.sv ----
`timescale 1ns/1ns
module snapshot_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic push;
    logic load;

    assign in_ready = (count_q != CW'(DEPTH));
    assign push = in_valid && in_ready;
    // refill the output register when it is empty or being drained
    assign load = (count_q != '0) && (!out_valid_q || out_ready);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            rd_ptr_q <= '0;
        end else if (load) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count_q <= '0;
        end else if (push && !load) begin
            count_q <= count_q + 1'b1;
        end else if (load && !push) begin
            count_q <= count_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (load) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rd_ptr_q];
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
        count_q <= CW'(DEPTH))
        else $error("fifo count beyond depth");

endmodule

// ---- core/serial_shift_latch_sink_driver.sv ----
`timescale 1ns/1ns
// Overview of operation
// - wipe low clears shift stages and latch
// - latch reaches outputs only with wipe high
// - enable low drives sinks from latch bits
// - enable high turns every sink off
// - latch strobe rise copies stages in parallel
// - shift strobe rise shifts input into stage0
// - twelve stages, chain output shows last
// - chain output updates on shift strobe fall
// - twelve independent open-drain sink outputs
// - bit one sinks current, zero is off
module serial_shift_latch_sink_driver
    import sink_driver_pkg::*;
#(
    parameter int CH = CHANNELS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_strobe,
    input wire logic latch_strobe,
    input wire logic chain_input,
    input wire logic wipe_low,
    input wire logic out_enable_low,
    input wire logic update_hold,
    input wire logic [CH-1:0] sink_outputs_sense,
    output logic [CH-1:0] sink_outputs_drive,
    output logic [CH-1:0] sink_outputs_oe,
    output logic chain_output,
    output logic snapshot_ready
);
    pin_bundle_t pins_raw;
    pin_bundle_t meta_q;
    pin_bundle_t sync_q;
    pin_bundle_t prev_q;
    logic shift_rise;
    logic shift_fall;
    logic latch_rise;
    logic wipe;
    logic [CH-1:0] stages_q;
    logic [CH-1:0] snap_q;
    logic snap_valid_q;
    logic [CH-1:0] storage_q;
    logic [CH-1:0] sink_oe_q;
    logic [CH-1:0] sink_o_q;
    logic chain_q;
    logic ready_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [CH-1:0] fifo_out_data;

    assign pins_raw = pin_bundle_t'({shift_strobe, latch_strobe,
        chain_input, wipe_low, out_enable_low});

    // two-flop synchroniser, then one more stage for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= PINS_RESET;
            sync_q <= PINS_RESET;
            prev_q <= PINS_RESET;
        end else begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // one-cycle pulses on both edges of the synced shift strobe and on the latch strobe rise
    assign shift_rise = sync_q.shift_strobe && !prev_q.shift_strobe;
    assign shift_fall = !sync_q.shift_strobe && prev_q.shift_strobe;
    assign latch_rise = sync_q.latch_strobe && !prev_q.latch_strobe;
    assign wipe = !sync_q.wipe_low;

    always_ff @(posedge clk) begin
        if (rst || wipe) begin
            stages_q <= LATCH_RESET;
        end else if (shift_rise) begin
            stages_q <= {stages_q[CH-2:0], sync_q.chain_input};
        end
    end

    // moving on the fall gives a cascaded part half a period of hold
    always_ff @(posedge clk) begin
        if (rst || wipe) begin
            chain_q <= CHAIN_RESET;
        end else if (shift_fall) begin
            chain_q <= stages_q[CH-1];
        end
    end

    // snapshot waits here while the fifo is full; a newer one replaces it
    always_ff @(posedge clk) begin
        if (rst || wipe) begin
            snap_valid_q <= 1'b0;
            snap_q <= LATCH_RESET;
        end else if (latch_rise) begin
            snap_valid_q <= 1'b1;
            snap_q <= stages_q;
        end else if (fifo_in_ready) begin
            snap_valid_q <= 1'b0;
        end
    end

    // snapshots queue here so a held update loses none up to depth
    snapshot_fifo #(
        .WIDTH(CH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .clear(wipe),
        .in_valid(snap_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(snap_q),
        .out_valid(fifo_out_valid),
        .out_ready(!update_hold),
        .out_data(fifo_out_data)
    );

    // storage takes the oldest queued snapshot once the hold lifts
    always_ff @(posedge clk) begin
        if (rst || wipe) begin
            storage_q <= LATCH_RESET;
        end else if (fifo_out_valid && !update_hold) begin
            storage_q <= fifo_out_data;
        end
    end

    // a one in the enable pulls that pad low, so the channel sinks
    always_ff @(posedge clk) begin
        if (rst || wipe || sync_q.out_enable_low) begin
            sink_oe_q <= '0;
        end else begin
            sink_oe_q <= storage_q;
        end
    end

    // open-drain: the pad level is only ever pulled low
    always_ff @(posedge clk) begin
        sink_o_q <= '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= fifo_in_ready;
        end
    end

    assign sink_outputs_drive = sink_o_q;
    assign sink_outputs_oe = sink_oe_q;
    assign chain_output = chain_q;
    assign snapshot_ready = ready_q;

    // checks see registered outputs one clock behind their cause
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_wipe_clears_regs: assert property (
        wipe |=> (stages_q == '0) && (storage_q == '0) && !chain_q)
        else $error("wipe did not clear registers");
    a_wipe_gates_out: assert property (
        wipe |=> sink_outputs_oe == '0 ##1 sink_outputs_oe == '0)
        else $error("outputs active during wipe");
    a_enable_drives_sinks: assert property (
        (!sync_q.out_enable_low && !wipe) |=>
            sink_outputs_oe == $past(storage_q))
        else $error("sinks do not follow latch");
    a_disable_all_off: assert property (
        sync_q.out_enable_low |=> sink_outputs_oe == '0)
        else $error("sink on while disabled");
    a_latch_snapshot: assert property (
        (latch_rise && !wipe) |=> snap_valid_q && snap_q == $past(stages_q))
        else $error("latch edge missed stages");
    a_latch_delivery: assert property (
        (snap_valid_q && fifo_in_ready && !fifo_out_valid && !wipe
            && u_fifo.count_q == '0) ##1 !wipe ##1 (!wipe && !update_hold)
            |=> storage_q == $past(snap_q, 3))
        else $error("snapshot never reached latch");
    a_latch_load: assert property (
        (fifo_out_valid && !update_hold && !wipe) |=>
            storage_q == $past(fifo_out_data))
        else $error("latch missed queued snapshot");
    a_full_keeps_pending: assert property (
        (snap_valid_q && !fifo_in_ready && !latch_rise && !wipe) |=>
            snap_valid_q && $stable(snap_q))
        else $error("pending snapshot lost while full");
    a_wipe_drops_snap: assert property (
        wipe |=> !snap_valid_q && !fifo_out_valid)
        else $error("wipe left a snapshot queued");

    a_hold_keeps_latch: assert property (
        (update_hold && !wipe) |=> $stable(storage_q))
        else $error("latch changed while held");
    a_shift_advance: assert property (
        (shift_rise && !wipe) |=> stages_q ==
            {$past(stages_q[CH-2:0]), $past(sync_q.chain_input)})
        else $error("shift stage mismatch");
    a_chain_on_fall: assert property (
        (shift_fall && !wipe) |=> chain_output == $past(stages_q[CH-1]))
        else $error("chain output not last stage");
    a_chain_quiet: assert property (
        (!shift_fall && !wipe) |=> $stable(chain_output))
        else $error("chain output moved off a falling edge");

    a_shift_idle: assert property (
        (!shift_rise && !wipe) |=> $stable(stages_q))
        else $error("stages moved without a shift edge");
    a_sink_never_high: assert property (
        sink_outputs_drive == '0)
        else $error("open-drain data not low");
    a_ready_mirrors_fifo: assert property (
        1'b1 |=> snapshot_ready == $past(fifo_in_ready))
        else $error("snapshot ready does not follow fifo");

    // main scenarios: shift then latch, back-pressure, drive, drain
    c_shift_then_latch: cover property (shift_rise ##[1:40] latch_rise);
    c_fifo_full: cover property (!fifo_in_ready && snap_valid_q);
    c_sink_on: cover property (sink_outputs_oe != '0);
    c_load_pulled: cover property (|(sink_outputs_oe & ~sink_outputs_sense));
    c_hold_drain: cover property ($fell(update_hold) && fifo_out_valid);

endmodule

// ---- testbench/host_model.sv ----
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    output logic shift_strobe,
    output logic latch_strobe,
    output logic chain_input,
    output logic wipe_low,
    output logic out_enable_low
);
    initial begin
        shift_strobe = 1'b0;
        latch_strobe = 1'b0;
        chain_input = 1'b0;
        wipe_low = 1'b1;
        out_enable_low = 1'b1;
    end
    // one half of a 32 ns link period
    task automatic half(input logic d, input logic s, input logic l);
        chain_input <= d;
        shift_strobe <= s;
        latch_strobe <= l;
        repeat (4) @(posedge clk);
    endtask
    // msb first; data moves on the fall and is held through the rise,
    // as a cascaded upstream chain output on a shared strobe would do
    task automatic shift_word(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) begin
            half(w[i], 1'b0, 1'b0);
            half(w[i], 1'b1, 1'b0);
        end
        half(~w[0], 1'b0, 1'b0);
    endtask
    task automatic latch();
        half(chain_input, 1'b0, 1'b1);
        half(chain_input, 1'b0, 1'b0);
    endtask
    task automatic pins(input logic w, input logic e);
        wipe_low <= w;
        out_enable_low <= e;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- testbench/serial_shift_latch_sink_driver_bench.sv ----
`timescale 1ns/1ns
module serial_shift_latch_sink_driver_bench;
    import sink_driver_pkg::*;
    localparam logic [11:0] WA = 12'hA5C;
    localparam logic [11:0] WB = 12'hC63;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic update_hold = 1'b0;
    logic sh, la, din, wipe_low, out_enable_low, chain_output, snap_rdy;
    logic [CHANNELS-1:0] pad, so, soe;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    // open-drain pads with pull-ups
    assign pad = ~soe | so;
    host_model host_model_inst (.clk(clk), .shift_strobe(sh),
        .latch_strobe(la), .chain_input(din), .wipe_low(wipe_low),
        .out_enable_low(out_enable_low));
    serial_shift_latch_sink_driver serial_shift_latch_sink_driver_inst (
        .clk(clk), .rst(rst), .shift_strobe(sh), .latch_strobe(la),
        .chain_input(din), .wipe_low(wipe_low),
        .out_enable_low(out_enable_low), .update_hold(update_hold),
        .sink_outputs_sense(pad), .sink_outputs_drive(so),
        .sink_outputs_oe(soe),
        .chain_output(chain_output), .snapshot_ready(snap_rdy));
    task automatic chk(input string n, input logic [11:0] e,
        input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic test_load();
        host_model_inst.shift_word(WA);
        host_model_inst.latch();
        host_model_inst.pins(1'b1, 1'b0);
        settle(6);
        chk("oe", WA, soe);
        chk("o", 12'h000, so);
        chk("pad", ~WA, pad);
        host_model_inst.pins(1'b1, 1'b1);
        settle(6);
        chk("oe_off", 12'h000, soe);
        host_model_inst.pins(1'b1, 1'b0);
        settle(6);
        chk("oe_on", WA, soe);
    endtask
    task automatic test_chain();
        logic e;
        e = WA[11];
        chk("chain0", {11'h000, e}, {11'h000, chain_output});
        for (int i = 0; i < 12; i++) begin
            host_model_inst.half(WB[11-i], 1'b0, 1'b0);
            host_model_inst.half(WB[11-i], 1'b1, 1'b0);
            chk("chain_hi", {11'h000, e}, {11'h000, chain_output});
            e = (i < 11) ? WA[10-i] : WB[11];
            host_model_inst.half(WB[11-i], 1'b0, 1'b0);
            settle(3);
            chk("chain_lo", {11'h000, e}, {11'h000, chain_output});
        end
    endtask
    task automatic test_fifo();
        update_hold <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            host_model_inst.latch();
        end
        settle(6);
        chk("held", WA, soe);
        chk("full", 12'h000, {11'h000, snap_rdy});
        update_hold <= 1'b0;
        settle(60);
        chk("drained", WB, soe);
    endtask
    task automatic test_wipe();
        host_model_inst.pins(1'b0, 1'b0);
        settle(6);
        chk("wipe_oe", 12'h000, soe);
        chk("wipe_ch", 12'h000, {11'h000, chain_output});
        host_model_inst.latch();
        host_model_inst.pins(1'b1, 1'b0);
        chk("wiped_latch", 12'h000, soe);
        host_model_inst.latch();
        settle(6);
        chk("cleared", 12'h000, soe);
    endtask
    initial begin
        settle(8);
        rst <= 1'b0;
        settle(3);
        chk("rst_oe", 12'h000, soe);
        test_load();
        test_chain();
        test_fifo();
        test_wipe();
        finish_test();
    end
endmodule
